// ==== src/page_reg_decode.sv ====
// Address decode of the control register and the three stack registers and read data selection.
// Assumes a combinational request from the core, same clock.
`timescale 1ns/1ps
`include "page_stack_cfg.svh"
module page_reg_decode
    import page_stack_pkg::*;
(
    // Request
    input  wire reg_req_t req,
    // Stored values
    input  wire page_t    active_page,
    input  wire page_t    page_stack_middle,
    input  wire page_t    page_stack_bottom,
    input  wire logic     auto_page_enable,
    // Decoded strobes and read data
    output logic          wr_control,
    output logic          wr_active,
    output logic          wr_middle,
    output logic          wr_bottom,
    output logic          hit,
    output logic [7:0]    rdata
);
    // ==========================================
    // Decode, independent of the selected page
    wire sel_control = req.addr == `ADDR_PAGE_CONTROL;
    wire sel_active  = req.addr == `ADDR_ACTIVE_PAGE;
    wire sel_middle  = req.addr == `ADDR_PAGE_STACK_MIDDLE;
    wire sel_bottom  = req.addr == `ADDR_PAGE_STACK_BOTTOM;
    wire [7:0] control_value = {7'h00, auto_page_enable};
    assign hit        = sel_control | sel_active | sel_middle | sel_bottom;
    assign wr_control = req.wr & sel_control;
    assign wr_active  = req.wr & sel_active;
    assign wr_middle  = req.wr & sel_middle;
    assign wr_bottom  = req.wr & sel_bottom;
    // Unmapped addresses read zero
    assign rdata = sel_control ? control_value :
                   sel_active  ? active_page :
                   sel_middle  ? page_stack_middle :
                   sel_bottom  ? page_stack_bottom : 8'h00;
endmodule // page_reg_decode

// ==== src/page_stack_cfg.svh ====
// Addresses, reset values and field positions of the page context stack.
// Assumes 8-bit direct register addresses issued by the processor core.
`ifndef PAGE_STACK_CFG_SVH
`define PAGE_STACK_CFG_SVH
`define ADDR_PAGE_CONTROL      8'h81
`define ADDR_ACTIVE_PAGE       8'h84
`define ADDR_PAGE_STACK_MIDDLE 8'h85
`define ADDR_PAGE_STACK_BOTTOM 8'h86
`define RESET_PAGE_CONTROL     8'h01
`define RESET_PAGE             8'h00
`define EMPTY_PAGE             8'h00
`define AUTO_PAGE_ENABLE_BIT   0
`define PAGE_WIDTH             8
`endif

// ==== src/page_stack_pkg.sv ====
// Types shared by the page context stack files.
// Assumes the configuration header is on the include path.
`include "page_stack_cfg.svh"
package page_stack_pkg;
    typedef logic [`PAGE_WIDTH-1:0] page_t;
    // One register access from the core
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
    // Interrupt sequencing events from the core
    typedef struct packed {
        logic  vector;
        page_t source_page;
        logic  ret;
    } irq_event_t;
    typedef enum logic [2:0] {
        op_idle = 3'b001,
        op_push = 3'b010,
        op_pop  = 3'b100
    } stack_op_t;
endpackage

// ==== src/sfr_page_context_stack.sv ====
// Three-entry page context stack with automatic page switching.
// Assumes the core gives one-cycle vector and return pulses on clk.
`timescale 1ns/1ps
`include "page_stack_cfg.svh"
module sfr_page_context_stack
    import page_stack_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Register access from the core
    input  wire reg_req_t   req,
    output logic [7:0]      rdata,
    output logic            rhit,
    // Interrupt sequencing from the core
    input  wire irq_event_t irq,
    // Page used for special_function_register accesses
    output page_t           page_select,
    output logic            auto_page_enable
);
    // ==========================================
    // State
    localparam logic [7:0] CONTROL_RESET = `RESET_PAGE_CONTROL;
    page_t     active_page;
    page_t     page_stack_middle;
    page_t     page_stack_bottom;
    logic      bottom_valid;
    page_t     next_active;
    page_t     next_middle;
    page_t     next_bottom;
    logic      next_valid;
    logic      next_enable;
    logic      wr_control;
    logic      wr_active;
    logic      wr_middle;
    logic      wr_bottom;
    stack_op_t op;

    // ==========================================
    // Decode
    page_reg_decode u_decode (
        .req               (req),
        .active_page       (active_page),
        .page_stack_middle (page_stack_middle),
        .page_stack_bottom (page_stack_bottom),
        .auto_page_enable  (auto_page_enable),
        .wr_control        (wr_control),
        .wr_active         (wr_active),
        .wr_middle         (wr_middle),
        .wr_bottom         (wr_bottom),
        .hit               (rhit),
        .rdata             (rdata)
    );

    // ==========================================
    // Stack operation select; vector wins if both arrive together
    assign op = !auto_page_enable ? op_idle :
                irq.vector        ? op_push :
                irq.ret           ? op_pop  : op_idle;

    // ==========================================
    // Next values; a hardware push or pop beats a same-cycle write
    always_comb begin
        next_active = active_page;
        next_middle = page_stack_middle;
        next_bottom = page_stack_bottom;
        next_valid  = bottom_valid;
        next_enable = auto_page_enable;
        if (wr_control) begin
            next_enable = req.wdata[`AUTO_PAGE_ENABLE_BIT];
        end
        if (wr_active) begin
            next_active = req.wdata;
        end
        if (wr_middle) begin
            next_middle = req.wdata;
        end
        if (wr_bottom) begin
            next_bottom = req.wdata;
            next_valid  = 1'b1;
        end
        unique case (op)
            op_push: begin
                next_bottom = page_stack_middle;
                next_valid  = 1'b1;
                next_middle = active_page;
                next_active = irq.source_page;
            end
            op_pop: begin
                next_active = page_stack_middle;
                next_middle = bottom_valid ? page_stack_bottom
                                           : `EMPTY_PAGE;
                next_bottom = `EMPTY_PAGE;
                next_valid  = 1'b0;
            end
            op_idle: begin
            end
        endcase
    end

    // ==========================================
    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            active_page       <= `RESET_PAGE;
            page_stack_middle <= `RESET_PAGE;
            page_stack_bottom <= `RESET_PAGE;
            bottom_valid      <= 1'b0;
            auto_page_enable  <= CONTROL_RESET[`AUTO_PAGE_ENABLE_BIT];
        end else begin
            active_page       <= next_active;
            page_stack_middle <= next_middle;
            page_stack_bottom <= next_bottom;
            bottom_valid      <= next_valid;
            auto_page_enable  <= next_enable;
        end
    end

    assign page_select = active_page;
endmodule // sfr_page_context_stack

// ==== testbench/core_model.sv ====
// Processor core model: register access and interrupt events.
// Assumes the bench calls cycle from one process.
`timescale 1ns/1ps
module core_model
    import page_stack_pkg::*;
(
    input  wire logic clk,
    output reg_req_t   req,
    output irq_event_t irq
);
    initial req = '0;
    initial irq = '0;
    // wr, vector and ret drop after the taken edge while rd stays high; stale data is inverted
    task automatic cycle(input logic w, input logic [7:0] a, d,
                         input logic v, input page_t s, input logic r);
        @(posedge clk);
        req <= '{rd: 1'b1, wr: w, addr: a, wdata: d};
        irq <= '{vector: v, source_page: s, ret: r};
        @(posedge clk);
        req.wr <= 1'b0;
        req.wdata <= ~d;
        irq <= '{vector: 1'b0, source_page: ~s, ret: 1'b0};
    endtask
endmodule // core_model

// ==== testbench/page_stack_monitor.sv ====
// Port checker of the page context stack.
// Assumes a bind from the bench top.
`timescale 1ns/1ps
module page_stack_monitor
    import page_stack_pkg::*;
(
    // Watched ports
    input wire logic       clk,
    input wire logic       rst,
    input wire reg_req_t   req,
    input wire logic [7:0] rdata,
    input wire logic       rhit,
    input wire irq_event_t irq,
    input wire page_t      page_select,
    input wire logic       auto_page_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // A vector beats a return in the same cycle
    sequence s_push; irq.vector && auto_page_enable; endsequence
    sequence s_pop; irq.ret && !irq.vector && auto_page_enable; endsequence
    wire quiet = !irq.vector && !irq.ret;
    wire wr_act = req.wr && req.addr == 8'h84;
    property p_push; s_push |=> page_select == $past(irq.source_page);
    endproperty
    property p_pop; s_pop ##0 req.addr == 8'h85 |=>
        page_select == $past(rdata); endproperty
    property p_hold; quiet && !wr_act |=> $stable(page_select); endproperty
    property p_off; !auto_page_enable && !wr_act |=> $stable(page_select);
    endproperty
    property p_wr; quiet && wr_act |=> page_select == $past(req.wdata);
    endproperty
    property p_en; req.wr && req.addr == 8'h81 |=>
        auto_page_enable == $past(req.wdata[0]); endproperty
    property p_rctl; req.addr == 8'h81 |-> rdata == {7'h00, auto_page_enable};
    endproperty
    property p_hit; rhit == (req.addr inside {8'h81, 8'h84, 8'h85, 8'h86});
    endproperty
    a_push: assert property (p_push) else $error("push page");
    a_pop: assert property (p_pop) else $error("pop page");
    a_hold: assert property (p_hold) else $error("page moved");
    a_off: assert property (p_off) else $error("page moved off");
    a_wr: assert property (p_wr) else $error("page write");
    a_en: assert property (p_en) else $error("enable write");
    a_rctl: assert property (p_rctl) else $error("control read");
    a_hit: assert property (p_hit) else $error("decode");
endmodule // page_stack_monitor

// ==== testbench/sfr_page_context_stack_tb_top.sv ====
// Bench of the page context stack.
// Assumes the core model and monitor are compiled first.
`timescale 1ns/1ps
module sfr_page_context_stack_tb_top
    import page_stack_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    reg_req_t    req;
    irq_event_t  irq;
    logic [7:0]  rdata;
    logic        rhit;
    logic        en;
    page_t       page;
    int          mismatches = 0;
    int          n_checks = 0;
    logic [23:0] rows [6] = '{24'h845A5A, 24'h85A5A5, 24'h863C3C,
                              24'h81FE00, 24'h810101, 24'h907700};
    always #50 clk = ~clk;
    core_model i_core (.clk(clk), .req(req), .irq(irq));
    sfr_page_context_stack i_dut (.clk(clk), .rst(rst), .req(req),
        .rdata(rdata), .rhit(rhit), .irq(irq), .page_select(page),
        .auto_page_enable(en));
    task automatic check(string what, logic [7:0] exp, logic [7:0] seen);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        i_core.cycle(1'b0, a, 8'h00, 1'b0, 8'h00, 1'b0);
        #1 check("rdata", exp, rdata);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            i_core.cycle(1'b1, rows[i][23:16], rows[i][15:8], 1'b0, 8'h00,
                         1'b0);
            rd(rows[i][23:16], rows[i][7:0]);
            check("rhit", {7'h00, (rows[i][23:16] inside {8'h81, 8'h84,
                  8'h85, 8'h86})}, {7'h00, rhit});
        end
        // Held two edges so no checker attempt straddles the release
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(8'h81, 8'h01);
        rd(8'h84, 8'h00);
        // Nested entry; the bottom write is lost to the first push
        i_core.cycle(1'b1, 8'h84, 8'h0F, 1'b0, 8'h00, 1'b0);
        i_core.cycle(1'b1, 8'h86, 8'h77, 1'b0, 8'h00, 1'b0);
        i_core.cycle(1'b0, 8'h85, 8'h00, 1'b1, 8'h02, 1'b0);
        i_core.cycle(1'b0, 8'h85, 8'h00, 1'b1, 8'h00, 1'b0);
        rd(8'h86, 8'h0F);
        rd(8'h85, 8'h02);
        check("page", 8'h00, page);
        i_core.cycle(1'b0, 8'h85, 8'h00, 1'b0, 8'h00, 1'b1);
        rd(8'h84, 8'h02);
        i_core.cycle(1'b0, 8'h85, 8'h00, 1'b0, 8'h00, 1'b1);
        rd(8'h85, 8'h00);
        check("page", 8'h0F, page);
        i_core.cycle(1'b1, 8'h85, 8'h44, 1'b0, 8'h00, 1'b0);
        i_core.cycle(1'b1, 8'h86, 8'h33, 1'b0, 8'h00, 1'b0);
        i_core.cycle(1'b0, 8'h85, 8'h00, 1'b0, 8'h00, 1'b1);
        #1 check("page", 8'h44, page);
        rd(8'h85, 8'h33);
        i_core.cycle(1'b1, 8'h81, 8'h00, 1'b0, 8'h00, 1'b0);
        i_core.cycle(1'b0, 8'h85, 8'h00, 1'b1, 8'h03, 1'b0);
        i_core.cycle(1'b0, 8'h85, 8'h00, 1'b0, 8'h00, 1'b1);
        #1 check("page", 8'h44, page);
        rd(8'h85, 8'h33);
        summarize();
    end
    initial begin
        #200us;
        mismatches++;
        summarize();
    end
endmodule // sfr_page_context_stack_tb_top
bind sfr_page_context_stack page_stack_monitor i_mon (.clk(clk), .rst(rst),
    .req(req), .rdata(rdata), .rhit(rhit), .irq(irq),
    .page_select(page_select), .auto_page_enable(auto_page_enable));
